// >>> core/sopm_consts.svh
`ifndef SOPM_CONSTS_SVH
`define SOPM_CONSTS_SVH

// register byte offsets
`define SOPM_OFF_SYSOPT_TWO    8'h00
`define SOPM_OFF_PART_HIGH     8'h04
`define SOPM_OFF_PART_LOW      8'h08
`define SOPM_OFF_PWR_ONE       8'h0c
`define SOPM_OFF_PWR_TWO       8'h10

// system options two fields
`define SOPM_B_WD_CLK_SEL      7
`define SOPM_B_WD_WINDOW       6
`define SOPM_B_CONV_TRIG_SEL   4
`define SOPM_B_DIV_HI          2
`define SOPM_B_DIV_LO          0

// power management one fields
`define SOPM_B_WARN_FLAG       7
`define SOPM_B_WARN_ACK        6
`define SOPM_B_WARN_IE         5
`define SOPM_B_UV_RST_EN       4
`define SOPM_B_UV_STOP_EN      3
`define SOPM_B_UV_DET_EN       2
`define SOPM_B_BG_EN           0

// power management two fields
`define SOPM_B_UV_LEVEL        5
`define SOPM_B_WARN_LEVEL      4
`define SOPM_B_PD_FLAG         3
`define SOPM_B_PD_ACK          2
`define SOPM_B_PD_MODE         0

// reset values, service sequence bytes and bus response codes
`define SOPM_RST_BYTE          8'h00
`define SOPM_WD_KEY_FIRST      8'h55
`define SOPM_WD_KEY_SECOND     8'haa
`define SOPM_RESP_OKAY         2'h0
`define SOPM_RESP_SLVERR       2'h2

`endif

// >>> core/sopm_pkg.sv
package sopm_pkg;

	typedef enum logic [2:0] {
		SOPM_REG_SYSOPT_TWO,
		SOPM_REG_PART_HIGH,
		SOPM_REG_PART_LOW,
		SOPM_REG_PWR_ONE,
		SOPM_REG_PWR_TWO,
		SOPM_REG_NONE
	} sopm_reg_t;

	typedef enum logic {
		SOPM_WD_IDLE,
		SOPM_WD_GOT_FIRST
	} sopm_wd_t;

	// status inputs from the analogue and stop-mode side
	typedef struct packed {
		logic below_warning;
		logic below_detect;
		logic in_stop;
		logic stop2_recovered;
	} sopm_supply_t;

	// everything cleared by rst_n; por_n alone does not clear it
	typedef struct packed {
		logic       aw_have;
		logic [7:0] aw_addr;
		logic       w_have;
		logic [7:0] w_data;
		logic       w_lane0;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic       wd_clk_sel;
		logic       wd_window;
		logic       conv_trig_sel;
		logic [2:0] clk_div;
		logic       sysopt_done;
		logic       warn_flag;
		logic       warn_ie;
		logic       uv_rst_en;
		logic       uv_stop_en;
		logic       uv_det_en;
		logic       bg_en;
		logic       pwr_one_done;
		logic       pd_flag;
		logic       pd_mode;
		logic       pd_done;
		sopm_wd_t   wd_seq;
		logic       wd_service;
		logic       wd_reset;
		logic [2:0] div_cnt;
		logic       clk_pin;
		logic       clk_pin_en;
		logic       conv_start;
		logic       wd_tick;
		logic       warn_irq;
		logic       uv_active;
		logic       uv_reset;
	} sopm_state_t;

	// cleared only by power-on reset
	typedef struct packed {
		logic uv_level;
		logic warn_level;
		logic level_done;
	} sopm_keep_t;

endpackage

// >>> core/sopm_regs.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sopm_consts.svh"

module sopm_regs
	import sopm_pkg::*;
#(
	parameter logic [11:0] PART_NUMBER = 12'h5a3, // arbitrary value
	parameter logic [3:0]  REVISION    = 4'h1     // arbitrary value
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         por_n,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         lpo_tick,
	input  wire logic         reset_status_wr,
	input  wire logic [7:0]   reset_status_wdata,
	input  wire logic         watchdog_late_window,
	output logic              watchdog_tick,
	output logic              watchdog_service,
	output logic              watchdog_window_reset,
	input  wire logic         converter_hw_trigger_enable,
	input  wire logic         rtc_overflow,
	input  wire logic         irq_pin_event,
	output logic              converter_start,
	output logic              clock_output_pin,
	output logic              clock_output_enable,
	input  wire sopm_supply_t supply,
	output logic              supply_warning_irq,
	output logic              undervoltage_active,
	output logic              undervoltage_reset_req,
	output logic              bandgap_buffer_enable,
	output logic              power_down_mode_select,
	output logic              undervoltage_level_select,
	output logic              warning_level_select
);

	sopm_state_t s_q, s_d;
	sopm_keep_t  k_q, k_d;

	// byte address to register, shared by read and write paths
	function automatic sopm_reg_t decode(input logic [7:0] addr);
		sopm_reg_t r;
		r = SOPM_REG_NONE;
		case ({addr[7:2], 2'b00})
			`SOPM_OFF_SYSOPT_TWO: r = SOPM_REG_SYSOPT_TWO;
			`SOPM_OFF_PART_HIGH:  r = SOPM_REG_PART_HIGH;
			`SOPM_OFF_PART_LOW:   r = SOPM_REG_PART_LOW;
			`SOPM_OFF_PWR_ONE:    r = SOPM_REG_PWR_ONE;
			`SOPM_OFF_PWR_TWO:    r = SOPM_REG_PWR_TWO;
			default:              r = SOPM_REG_NONE;
		endcase
		return r;
	endfunction

	// read view of every register; ack bits always read zero
	function automatic logic [7:0] read_byte(input sopm_reg_t r, input sopm_state_t s,
	                                         input sopm_keep_t k);
		logic [7:0] v;
		v = `SOPM_RST_BYTE;
		case (r)
			SOPM_REG_SYSOPT_TWO: begin
				v[`SOPM_B_WD_CLK_SEL]               = s.wd_clk_sel;
				v[`SOPM_B_WD_WINDOW]                = s.wd_window;
				v[`SOPM_B_CONV_TRIG_SEL]            = s.conv_trig_sel;
				v[`SOPM_B_DIV_HI:`SOPM_B_DIV_LO]    = s.clk_div;
			end
			SOPM_REG_PART_HIGH: v = {REVISION, PART_NUMBER[11:8]};
			SOPM_REG_PART_LOW:  v = PART_NUMBER[7:0];
			SOPM_REG_PWR_ONE: begin
				v[`SOPM_B_WARN_FLAG]  = s.warn_flag;
				v[`SOPM_B_WARN_IE]    = s.warn_ie;
				v[`SOPM_B_UV_RST_EN]  = s.uv_rst_en;
				v[`SOPM_B_UV_STOP_EN] = s.uv_stop_en;
				v[`SOPM_B_UV_DET_EN]  = s.uv_det_en;
				v[`SOPM_B_BG_EN]      = s.bg_en;
			end
			SOPM_REG_PWR_TWO: begin
				v[`SOPM_B_UV_LEVEL]   = k.uv_level;
				v[`SOPM_B_WARN_LEVEL] = k.warn_level;
				v[`SOPM_B_PD_FLAG]    = s.pd_flag;
				v[`SOPM_B_PD_MODE]    = s.pd_mode;
			end
			default: v = `SOPM_RST_BYTE;
		endcase
		return v;
	endfunction

	// all next-state logic in one place
	always_comb begin
		logic       wr_go;
		logic [7:0] wd;
		sopm_reg_t  wr_reg;
		sopm_reg_t  rd_reg;
		logic       uv_run;
		wr_go  = 1'b0;
		wd     = 8'h00;
		wr_reg = SOPM_REG_NONE;
		rd_reg = SOPM_REG_NONE;
		uv_run = 1'b0;
		s_d = s_q;
		k_d = k_q;

		// write channels taken independently, in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_have  = 1'b1;
			s_d.w_data  = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		// the write lands one edge after both halves are held
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			wr_reg      = decode(s_q.aw_addr);
			wr_go       = s_q.w_lane0 && (wr_reg != SOPM_REG_NONE);
			wd          = s_q.w_data;
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = (wr_reg == SOPM_REG_NONE) ? `SOPM_RESP_SLVERR : `SOPM_RESP_OKAY;
		end
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;

		// read answered on the same edge that takes the address
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.arready) begin
			rd_reg     = decode(s_axi_araddr);
			s_d.rvalid = 1'b1;
			s_d.rdata  = read_byte(rd_reg, s_q, k_q);
			s_d.rresp  = (rd_reg == SOPM_REG_NONE) ? `SOPM_RESP_SLVERR : `SOPM_RESP_OKAY;
		end
		s_d.arready = !s_d.rvalid;

		// register writes; partly written bytes count as a write
		if (wr_go) begin
			case (wr_reg)
				SOPM_REG_SYSOPT_TWO: begin
					if (!s_q.sysopt_done) begin
						s_d.wd_clk_sel = wd[`SOPM_B_WD_CLK_SEL];
						s_d.wd_window  = wd[`SOPM_B_WD_WINDOW];
					end
					s_d.sysopt_done   = 1'b1;
					s_d.conv_trig_sel = wd[`SOPM_B_CONV_TRIG_SEL];
					s_d.clk_div       = wd[`SOPM_B_DIV_HI:`SOPM_B_DIV_LO];
				end
				SOPM_REG_PWR_ONE: begin
					if (!s_q.pwr_one_done) begin
						s_d.uv_rst_en = wd[`SOPM_B_UV_RST_EN];
						s_d.uv_det_en = wd[`SOPM_B_UV_DET_EN];
					end
					s_d.pwr_one_done = 1'b1;
					s_d.warn_ie      = wd[`SOPM_B_WARN_IE];
					s_d.uv_stop_en   = wd[`SOPM_B_UV_STOP_EN];
					s_d.bg_en        = wd[`SOPM_B_BG_EN];
					if (wd[`SOPM_B_WARN_ACK])
						s_d.warn_flag = 1'b0;
				end
				SOPM_REG_PWR_TWO: begin
					if (!k_q.level_done)
						k_d.uv_level = wd[`SOPM_B_UV_LEVEL];
					k_d.level_done = 1'b1;
					k_d.warn_level = wd[`SOPM_B_WARN_LEVEL];
					if (!s_q.pd_done)
						s_d.pd_mode = wd[`SOPM_B_PD_MODE];
					s_d.pd_done = 1'b1;
					if (wd[`SOPM_B_PD_ACK])
						s_d.pd_flag = 1'b0;
				end
				default: ;
			endcase
		end

		// hardware sets win over the acknowledge; warning holds while still low
		if (supply.below_warning)
			s_d.warn_flag = 1'b1;
		if (supply.stop2_recovered)
			s_d.pd_flag = 1'b1;

		// undervoltage detect gating by enable and stop mode
		uv_run         = s_q.uv_det_en && (!supply.in_stop || s_q.uv_stop_en);
		s_d.uv_active  = uv_run;
		s_d.uv_reset   = uv_run && s_q.uv_rst_en && supply.below_detect;
		s_d.warn_irq   = s_d.warn_flag && s_d.warn_ie;

		// watchdog clock route and service sequence
		s_d.wd_tick    = s_q.wd_clk_sel ? 1'b1 : lpo_tick;
		s_d.wd_service = 1'b0;
		s_d.wd_reset   = 1'b0;
		if (reset_status_wr) begin
			if (s_q.wd_window && !watchdog_late_window) begin
				s_d.wd_reset = 1'b1;
				s_d.wd_seq   = SOPM_WD_IDLE;
			end else begin
				case (s_q.wd_seq)
					SOPM_WD_IDLE:
						if (reset_status_wdata == `SOPM_WD_KEY_FIRST)
							s_d.wd_seq = SOPM_WD_GOT_FIRST;
					SOPM_WD_GOT_FIRST: begin
						s_d.wd_seq = SOPM_WD_IDLE;
						if (reset_status_wdata == `SOPM_WD_KEY_SECOND)
							s_d.wd_service = 1'b1;
						else if (reset_status_wdata == `SOPM_WD_KEY_FIRST)
							s_d.wd_seq = SOPM_WD_GOT_FIRST;
					end
					default: s_d.wd_seq = SOPM_WD_IDLE;
				endcase
			end
		end

		// converter start source select
		s_d.conv_start = converter_hw_trigger_enable &&
		                 (s_q.conv_trig_sel ? irq_pin_event : rtc_overflow);

		// clock output: toggle every clk_div cycles for a period of 2*clk_div
		if (s_q.clk_div == 3'h0) begin
			s_d.div_cnt    = 3'h0;
			s_d.clk_pin    = 1'b0;
			s_d.clk_pin_en = 1'b0;
		end else begin
			s_d.clk_pin_en = 1'b1;
			if (s_q.div_cnt >= s_q.clk_div - 3'h1) begin
				s_d.div_cnt = 3'h0;
				s_d.clk_pin = !s_q.clk_pin;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 3'h1;
			end
		end
	end

	// rst_n clears this state; por_n alone does not
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// level selects ride through every reset but power-on
	always_ff @(posedge core_clk or negedge por_n) begin
		if (!por_n)
			k_q <= '0;
		else
			k_q <= k_d;
	end

	assign s_axi_awready             = s_q.awready;
	assign s_axi_wready              = s_q.wready;
	assign s_axi_bvalid              = s_q.bvalid;
	assign s_axi_bresp               = s_q.bresp;
	assign s_axi_arready             = s_q.arready;
	assign s_axi_rvalid              = s_q.rvalid;
	assign s_axi_rresp               = s_q.rresp;
	assign s_axi_rdata               = {24'h000000, s_q.rdata};
	assign watchdog_tick             = s_q.wd_tick;
	assign watchdog_service          = s_q.wd_service;
	assign watchdog_window_reset     = s_q.wd_reset;
	assign converter_start           = s_q.conv_start;
	assign clock_output_pin          = s_q.clk_pin;
	assign clock_output_enable       = s_q.clk_pin_en;
	assign supply_warning_irq        = s_q.warn_irq;
	assign undervoltage_active       = s_q.uv_active;
	assign undervoltage_reset_req    = s_q.uv_reset;
	assign bandgap_buffer_enable     = s_q.bg_en;
	assign power_down_mode_select    = s_q.pd_mode;
	assign undervoltage_level_select = k_q.uv_level;
	assign warning_level_select      = k_q.warn_level;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !por_n);

	sequence late_first;
		reset_status_wr && !(s_q.wd_window && !watchdog_late_window) &&
		reset_status_wdata == `SOPM_WD_KEY_FIRST;
	endsequence
	sequence late_second;
		reset_status_wr && !(s_q.wd_window && !watchdog_late_window) &&
		reset_status_wdata == `SOPM_WD_KEY_SECOND;
	endsequence

	service_seq_a: assert property (late_first ##1 late_second |=> watchdog_service)
		else $error("service sequence not honoured");
	early_write_a: assert property (
		reset_status_wr && s_q.wd_window && !watchdog_late_window
		|=> watchdog_window_reset && !watchdog_service)
		else $error("early watchdog write did not reset");
	trigger_route_a: assert property (
		converter_hw_trigger_enable && s_q.conv_trig_sel &&
		irq_pin_event |=> converter_start)
		else $error("interrupt pin trigger lost");
	clkout_off_a: assert property (
		s_q.clk_div == 3'h0 |=> !clock_output_enable
		&& !clock_output_pin)
		else $error("clock output active with zero divide");
	clkout_half_a: assert property (
		s_q.clk_div == 3'h2 && $stable(s_q.clk_div) && $changed(clock_output_pin)
		##1 s_q.clk_div == 3'h2
		|-> $stable(clock_output_pin) ##1 (s_q.clk_div != 3'h2 || $changed(clock_output_pin)))
		else $error("clock output half period wrong");
	once_only_a: assert property (
		s_q.sysopt_done |=> $stable(s_q.wd_clk_sel)
		&& $stable(s_q.wd_window))
		else $error("write-once bit changed twice");
	warn_hold_a: assert property (supply.below_warning |=> s_q.warn_flag)
		else $error("warning flag not set");
	// same-cycle check: an acknowledge may drop flag and request together
	warn_irq_a: assert property (
		supply_warning_irq == (s_q.warn_flag && s_q.warn_ie))
		else $error("warning interrupt missing");
	uv_gate_a: assert property (
		!s_q.uv_det_en |=> !undervoltage_reset_req
		&& !undervoltage_active)
		else $error("detect acted while disabled");
	level_once_a: assert property (k_q.level_done |=> $stable(k_q.uv_level))
		else $error("level select changed after first write");

	// routes and gates the checks above leave open
	rtc_route_a: assert property (
		converter_hw_trigger_enable && !s_q.conv_trig_sel && rtc_overflow |=> converter_start)
		else $error("counter overflow trigger lost");
	bus_clock_a: assert property (
		s_q.wd_clk_sel |=> watchdog_tick)
		else $error("watchdog clock not on bus clock");
	slow_clock_a: assert property (
		!s_q.wd_clk_sel && !lpo_tick |=> !watchdog_tick)
		else $error("watchdog clock ran without a tick");
	clkout_on_a: assert property (
		s_q.clk_div != 3'h0 |=> clock_output_enable)
		else $error("clock output off with nonzero divide");
	uv_reset_a: assert property (
		s_q.uv_det_en && s_q.uv_rst_en && !supply.in_stop && supply.below_detect
		|=> undervoltage_reset_req)
		else $error("detect event did not request reset");
	stop_gate_a: assert property (
		s_q.uv_det_en && supply.in_stop && !s_q.uv_stop_en |=> !undervoltage_active)
		else $error("detect ran in stop while disabled there");
	pd_flag_set_a: assert property (
		supply.stop2_recovered |=> s_q.pd_flag)
		else $error("recovered flag not set");
	pd_once_a: assert property (
		s_q.pd_done |=> $stable(s_q.pd_mode))
		else $error("power-down select changed twice");

endmodule
`default_nettype wire

// >>> tb/sopm_testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sopm_consts.svh"

module testbench
	import sopm_pkg::*;
;
	// arbitrary identity values, unlike the design defaults on purpose
	localparam logic [11:0] PNUM = 12'h2c7;
	localparam logic [3:0]  REV  = 4'h3;

	logic         core_clk, rst_n, por_n;
	logic [7:0]   s_axi_awaddr, s_axi_araddr, reset_status_wdata;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	logic         lpo_tick, reset_status_wr, watchdog_late_window;
	logic         watchdog_tick, watchdog_service, watchdog_window_reset;
	logic         converter_hw_trigger_enable, rtc_overflow, irq_pin_event;
	logic         converter_start, clock_output_pin, clock_output_enable;
	logic         supply_warning_irq, undervoltage_active, undervoltage_reset_req;
	logic         bandgap_buffer_enable, power_down_mode_select;
	logic         undervoltage_level_select, warning_level_select;
	sopm_supply_t supply;
	int           errors;
	int           checks_done;

	sopm_regs #(.PART_NUMBER(PNUM), .REVISION(REV)) dut (
		.core_clk, .rst_n, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lpo_tick,
		.reset_status_wr, .reset_status_wdata, .watchdog_late_window, .watchdog_tick,
		.watchdog_service, .watchdog_window_reset, .converter_hw_trigger_enable,
		.rtc_overflow, .irq_pin_event, .converter_start, .clock_output_pin,
		.clock_output_enable, .supply, .supply_warning_irq, .undervoltage_active,
		.undervoltage_reset_req, .bandgap_buffer_enable, .power_down_mode_select,
		.undervoltage_level_select, .warning_level_select
	);

	// 20 mhz bus clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// bus write: both halves offered together, bready held until the answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic       done;
		logic [1:0] r;
		done = 1'b0;
		r = 2'h3;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
		chk(r, er, "write response");
	endtask

	// bus read; waits for the answer however long, only the hang guard ends it
	task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic        done;
		logic [1:0]  r;
		logic [31:0] d;
		done = 1'b0;
		r = 2'h3;
		d = 32'h0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				r = s_axi_rresp;
				d = s_axi_rdata;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
		chk(r, er, "read response");
		chk(d, {24'h0, ed}, "read data");
	endtask

	task automatic do_reset(input logic por);
		@(posedge core_clk);
		rst_n <= 1'b0;
		por_n <= ~por;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		@(posedge core_clk);
	endtask

	// one low-power tick, then the watchdog clock one cycle later and after
	task automatic t_tick(input logic exp_after);
		@(posedge core_clk);
		lpo_tick <= 1'b1;
		@(posedge core_clk);
		lpo_tick <= 1'b0;
		@(negedge core_clk);
		chk(watchdog_tick, 1'b1, "watchdog clock on tick");
		@(negedge core_clk);
		chk(watchdog_tick, exp_after, "watchdog clock after tick");
	endtask

	// one trigger pulse from the pin or the counter overflow
	task automatic t_trig(input logic en, input logic pin, input logic exp);
		@(posedge core_clk);
		converter_hw_trigger_enable <= en;
		if (pin) irq_pin_event <= 1'b1;
		else rtc_overflow <= 1'b1;
		@(posedge core_clk);
		irq_pin_event <= 1'b0;
		rtc_overflow <= 1'b0;
		@(negedge core_clk);
		chk(converter_start, exp, "conversion start");
	endtask

	// cycles between two rising edges of the clock output pin
	task automatic t_period(input int exp);
		int   c;
		logic p;
		for (int k = 0; k < 2; k++) begin
			c = 0;
			do begin
				p = clock_output_pin;
				@(negedge core_clk);
				c++;
			end while (!(clock_output_pin && !p) && c < 40);
		end
		chk(c, exp, "clock output period");
	endtask

	task automatic test_ident();
		rd(`SOPM_OFF_PART_HIGH, {REV, PNUM[11:8]}, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PART_LOW, PNUM[7:0], `SOPM_RESP_OKAY);
		// lane 0 off: nothing lands and the write-once bits stay unspent
		s_axi_wstrb <= 4'h0;
		wr(`SOPM_OFF_SYSOPT_TWO, 8'hff, `SOPM_RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(`SOPM_OFF_SYSOPT_TWO, 8'h00, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_ONE, 8'h00, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_TWO, 8'h00, `SOPM_RESP_OKAY);
		rd(8'h14, 8'h00, `SOPM_RESP_SLVERR);
		wr(8'h14, 8'h5a, `SOPM_RESP_SLVERR);
		$display("test ident done");
	endtask

	task automatic test_sysopt();
		wr(`SOPM_OFF_SYSOPT_TWO, 8'h52, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_SYSOPT_TWO, 8'h52, `SOPM_RESP_OKAY);
		t_tick(1'b0);
		chk(clock_output_enable, 1'b1, "clock output on");
		t_period(4);
		t_trig(1'b1, 1'b1, 1'b1);
		t_trig(1'b1, 1'b0, 1'b0);
		t_trig(1'b0, 1'b1, 1'b0);
		// early write in window mode, then a full service sequence late
		@(posedge core_clk);
		reset_status_wr <= 1'b1;
		reset_status_wdata <= `SOPM_WD_KEY_FIRST;
		@(posedge core_clk);
		reset_status_wr <= 1'b0;
		watchdog_late_window <= 1'b1;
		@(negedge core_clk);
		chk(watchdog_window_reset, 1'b1, "early service write");
		@(posedge core_clk);
		reset_status_wr <= 1'b1;
		@(posedge core_clk);
		reset_status_wdata <= `SOPM_WD_KEY_SECOND;
		@(posedge core_clk);
		reset_status_wr <= 1'b0;
		@(negedge core_clk);
		chk(watchdog_service, 1'b1, "late service");
		chk(watchdog_window_reset, 1'b0, "late service no reset");
		// the two write-once bits ignore this second write
		wr(`SOPM_OFF_SYSOPT_TWO, 8'h97, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_SYSOPT_TWO, 8'h57, `SOPM_RESP_OKAY);
		t_period(14);
		wr(`SOPM_OFF_SYSOPT_TWO, 8'h00, `SOPM_RESP_OKAY);
		t_trig(1'b1, 1'b0, 1'b1);
		repeat (20) @(negedge core_clk);
		chk({clock_output_enable, clock_output_pin}, 2'b00, "clock output off");
		$display("test system options done");
	endtask

	task automatic test_pwr_one();
		@(posedge core_clk);
		supply.below_warning <= 1'b1;
		wr(`SOPM_OFF_PWR_ONE, 8'h3d, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_ONE, 8'hbd, `SOPM_RESP_OKAY);
		chk({supply_warning_irq, bandgap_buffer_enable}, 2'b11, "irq and buffer");
		// acknowledge refused while the supply is still low
		wr(`SOPM_OFF_PWR_ONE, 8'h6d, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_ONE, 8'hbd, `SOPM_RESP_OKAY);
		supply.below_detect <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk({undervoltage_active, undervoltage_reset_req}, 2'b11, "detect reset");
		@(posedge core_clk);
		supply.below_warning <= 1'b0;
		wr(`SOPM_OFF_PWR_ONE, 8'h40, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_ONE, 8'h14, `SOPM_RESP_OKAY);
		chk({supply_warning_irq, bandgap_buffer_enable}, 2'b00, "irq and buffer off");
		// stop mode with detection off in stop, then on
		supply.in_stop <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk({undervoltage_active, undervoltage_reset_req}, 2'b00, "stop gating");
		wr(`SOPM_OFF_PWR_ONE, 8'h08, `SOPM_RESP_OKAY);
		repeat (3) @(negedge core_clk);
		chk({undervoltage_active, undervoltage_reset_req}, 2'b11, "stop detect");
		@(posedge core_clk);
		supply.in_stop <= 1'b0;
		supply.below_detect <= 1'b0;
		$display("test power one done");
	endtask

	task automatic test_pwr_two();
		@(posedge core_clk);
		supply.stop2_recovered <= 1'b1;
		@(posedge core_clk);
		supply.stop2_recovered <= 1'b0;
		rd(`SOPM_OFF_PWR_TWO, 8'h08, `SOPM_RESP_OKAY);
		// the first write spends the once, so it must carry the wanted selects
		wr(`SOPM_OFF_PWR_TWO, 8'h31, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_TWO, 8'h39, `SOPM_RESP_OKAY);
		chk({power_down_mode_select, undervoltage_level_select, warning_level_select},
			3'b111, "mode and levels");
		wr(`SOPM_OFF_PWR_TWO, 8'h04, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_TWO, 8'h21, `SOPM_RESP_OKAY);
		wr(`SOPM_OFF_PWR_TWO, 8'h14, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_TWO, 8'h31, `SOPM_RESP_OKAY);
		// plain reset keeps the level selects, and the once stays spent
		do_reset(1'b0);
		rd(`SOPM_OFF_PWR_TWO, 8'h30, `SOPM_RESP_OKAY);
		wr(`SOPM_OFF_PWR_TWO, 8'h00, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_TWO, 8'h20, `SOPM_RESP_OKAY);
		supply.below_warning <= 1'b1;
		do_reset(1'b1);
		rd(`SOPM_OFF_PWR_TWO, 8'h00, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_PWR_ONE, 8'h80, `SOPM_RESP_OKAY);
		wr(`SOPM_OFF_SYSOPT_TWO, 8'h80, `SOPM_RESP_OKAY);
		rd(`SOPM_OFF_SYSOPT_TWO, 8'h80, `SOPM_RESP_OKAY);
		t_tick(1'b1);
		$display("test power two done");
	endtask

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#(50 * 20000);
		errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		end_sim();
	end

	// everything driven from time zero, both resets held six cycles
	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		por_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{lpo_tick, reset_status_wr, watchdog_late_window, rtc_overflow} = 4'h0;
		{converter_hw_trigger_enable, irq_pin_event} = 2'h0;
		reset_status_wdata = 8'h00;
		supply = '0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		test_ident();
		test_sysopt();
		test_pwr_one();
		test_pwr_two();
		end_sim();
	end
endmodule
`default_nettype wire
